// [pkg/lcc_regs.svh]
// Purpose: register map and fixed counts of the logic cluster.
// Assumes: 32-bit AHB-Lite words at byte addresses.
// Notes: word layouts are the package types.
// Behaviour
// RULE_01: Four-input table realises any function.
// RULE_02: Fourth table input picks carry or data.
// RULE_03: Register packing and register feedback in general mode.
// RULE_04: Arithmetic mode: full-adder bit with carry.
// RULE_05: Arithmetic mode keeps both outputs, packing, feedback.
// RULE_06: Carry chain continues into next cluster below.
// RULE_07: Sixteen cells, control, carry, register chain, routing.
// RULE_08: Register chain shifts one cell to the next.
// RULE_09: Outputs reach local and neighbouring clusters.
// RULE_10: Two clocks, enables, clears, one sclr, sload.
// RULE_11: Packing never combined with synchronous load.
// RULE_12: At most four non-global control sources.
// RULE_13: Synchronous clear and load hit every register.
// RULE_14: Each cluster clock paired with its enable.
// RULE_15: Both edges consume both cluster clocks.
// RULE_16: Inactive enable stops its cluster clock.
// RULE_17: Controls come from row clocks and local routing.
// RULE_18: Each register picks one of two clears.
// RULE_19: Preset by inverting register input and output.
// RULE_20: Enabled device reset clears all, overrides everything.
// RULE_21: Register acts as D, T, JK or SR.
// RULE_22: Table output can bypass the register.
// RULE_23: Device reset active low; clears beat synchronous controls.
`ifndef LCC_REGS_SVH
`define LCC_REGS_SVH
// =====================================================================
// Sizes
`define LCC_CELLS 16
`define LCC_ROW_LINES 6
`define LCC_SEL_W 6
// =====================================================================
// Register offsets
`define LCC_BLOCK_MASK 8'hc0
`define LCC_OFF_CFG 8'h00
`define LCC_OFF_ROUTE 8'h40
`define LCC_OFF_CTRL 8'h80
`define LCC_OFF_STAT 8'h84
`define LCC_OFF_COMB 8'h88
`define LCC_IDX_HI 5
`define LCC_IDX_LO 2
// =====================================================================
// Reset values and bus codes
`define LCC_RST_SYNC 2'h3
`define LCC_RESP_OKAY 1'h0
`define LCC_HTRANS_BIT 1
`endif

// [pkg/lcc_pkg.sv]
// Purpose: types of the logic cluster.
// Assumes: one 32-bit word per configuration register.
// Notes: fields are listed from the most significant bit down.
package lcc_pkg;
	typedef enum logic [1:0] {LCC_FF_D, LCC_FF_T, LCC_FF_JK, LCC_FF_SR} lcc_ff_e;
	typedef struct packed {
		logic [4:0] spare;
		logic out_reg;
		logic feedback;
		logic chain;
		logic pack;
		logic preset;
		lcc_ff_e ff;
		logic aclr_sel;
		logic clk_sel;
		logic cin_sel;
		logic arith;
		logic [15:0] mask;
	} lcc_cfg_s;
	typedef struct packed {
		logic [21:0] spare;
		logic carry_en;
		logic dev_rst_en;
		logic clk2_fall;
		logic [2:0] clk2_sel;
		logic clk1_fall;
		logic [2:0] clk1_sel;
	} lcc_ctrl_s;
endpackage

// [rtl/lcc_cell.sv]
// Purpose: one logic cell: four-input table, adder bit and register.
// Assumes: cluster clocks arrive as one-cycle ticks on i_clock.
// Notes: the stored bit is inverted when preset is chosen.
module lcc_cell (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_srst,
	// Configuration and data
	input wire logic [31:0] i_cfg,
	input wire logic [3:0] i_data,
	input wire logic i_carry_in,
	input wire logic i_chain_in,
	// Cluster controls
	input wire logic i_tick_one,
	input wire logic i_tick_two,
	input wire logic i_clear_one,
	input wire logic i_clear_two,
	input wire logic i_sync_clear,
	input wire logic i_sync_load,
	input wire logic i_dev_clr,
	// Results
	output logic o_lut,
	output logic o_q,
	output logic o_carry_out
);
	typedef struct packed {
		logic q;
	} lcc_cell_s;
	lcc_cell_s st_r;
	lcc_cell_s st_nxt;
	lcc_pkg::lcc_cfg_s cfg;
	logic [3:0] lut_in;
	logic qe, src, nx, tick, aclr;

	always_comb begin
		cfg = lcc_pkg::lcc_cfg_s'(i_cfg);
		lut_in = i_data;
		if (cfg.feedback) lut_in[0] = st_r.q ^ cfg.preset; // RULE_03 RULE_05
		if (cfg.cin_sel) lut_in[3] = i_carry_in; // RULE_02
		o_lut = cfg.mask[lut_in]; // RULE_01
		o_carry_out = 1'b0;
		if (cfg.arith) begin
			o_lut = lut_in[0] ^ lut_in[1] ^ i_carry_in; // RULE_04
			o_carry_out = (lut_in[0] & lut_in[1]) | (i_carry_in & (lut_in[0] ^ lut_in[1]));
		end
		qe = st_r.q ^ cfg.preset; // RULE_19
		src = cfg.pack ? i_data[3] : o_lut; // RULE_03 RULE_05
		if (cfg.chain) src = i_chain_in; // RULE_08
		unique case (cfg.ff) // RULE_21
			lcc_pkg::LCC_FF_D: nx = src;
			lcc_pkg::LCC_FF_T: nx = qe ^ src;
			lcc_pkg::LCC_FF_JK: nx = (src & ~qe) | (~i_data[1] & qe);
			lcc_pkg::LCC_FF_SR: nx = src | (qe & ~i_data[1]);
		endcase
		tick = cfg.clk_sel ? i_tick_two : i_tick_one; // RULE_14
		aclr = cfg.aclr_sel ? i_clear_two : i_clear_one; // RULE_18
		st_nxt = st_r;
		// Clears need no cluster clock, so they act even while it is stopped.
		if (i_dev_clr || aclr) begin
			st_nxt.q = 1'b0; // RULE_20 RULE_23
		end else if (tick) begin
			if (i_sync_clear) st_nxt.q = 1'b0; // RULE_13
			else if (i_sync_load) st_nxt.q = i_data[2] ^ cfg.preset;
			else st_nxt.q = nx ^ cfg.preset; // RULE_19
		end
		o_q = st_r.q ^ cfg.preset;
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) st_r <= '0;
		else st_r <= st_nxt;
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);

	chk_gated_hold: assert property ( // RULE_16
		!tick && !aclr && !i_dev_clr |=> $stable(st_r.q)
	) else $error("Cell register moved with its clock stopped.");
	chk_clear_beats_load: assert property ( // RULE_23
		aclr && tick && i_sync_load |=> !st_r.q
	) else $error("Load won over the clear.");
	chk_device_clear: assert property ( // RULE_20
		i_dev_clr |=> !st_r.q
	) else $error("Device reset did not clear the cell.");
	chk_adder_bit: assert property ( // RULE_04
		cfg.arith |-> {o_carry_out, o_lut} ==
			({1'b0, lut_in[0]} + {1'b0, lut_in[1]} + {1'b0, i_carry_in})
	) else $error("Adder bit result is wrong.");
endmodule // lcc_cell

// [rtl/lcc_cluster.sv]
// Purpose: one logic cluster of sixteen cells with shared controls.
// Assumes: one clock; cluster clocks are ticks made from row lines.
// Notes: every output is registered, so results lag by one cycle.
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`include "lcc_regs.svh"

module lcc_cluster (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_srst,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic [31:0] o_hrdata,
	output logic o_hresp,
	// Cluster control sources
	input wire logic [5:0] i_row_clock,
	input wire logic i_cluster_clock_enable_one,
	input wire logic i_cluster_clock_enable_two,
	input wire logic i_cluster_async_clear_one,
	input wire logic i_cluster_async_clear_two,
	input wire logic i_sync_clear,
	input wire logic i_sync_load,
	input wire logic i_device_wide_reset_n,
	// Routing into the cluster
	input wire logic [15:0] i_interconnect,
	input wire logic [15:0] i_left_link,
	input wire logic [15:0] i_right_link,
	input wire logic i_carry_in,
	input wire logic i_reg_chain_in,
	// Cell results
	output logic [15:0] o_cell_comb,
	output logic [15:0] o_cell_reg,
	output logic [15:0] o_direct_link,
	output logic o_carry_out,
	output logic o_reg_chain_out
);
	localparam int N = `LCC_CELLS;
	localparam int SW = `LCC_SEL_W;
	localparam int RL = `LCC_ROW_LINES;

	// =================================================================
	// State
	typedef struct packed {
		lcc_pkg::lcc_cfg_s [N-1:0] cfg;
		logic [N-1:0][3:0][SW-1:0] route;
		lcc_pkg::lcc_ctrl_s ctrl;
		logic [RL-1:0] row_prev;
		logic [1:0] rst_sync;
		logic ph_valid;
		logic ph_write;
		logic [7:0] ph_addr;
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
		logic [N-1:0] comb;
		logic [N-1:0] q;
		logic [N-1:0] direct;
		logic [N-1:0] local_out;
		logic carry_out;
		logic chain_out;
	} lcc_cluster_s;

	lcc_cluster_s st_r;
	lcc_cluster_s st_nxt;
	logic [4*N-1:0] pool;
	logic edge_one;
	logic edge_two;
	logic tick_one;
	logic tick_two;
	logic dev_clr;
	logic take;
	logic wr;
	logic [N-1:0] pmask;
	wire [N:0] carry;
	wire [N:0] chain;
	wire [N-1:0] cell_lut;
	wire [N-1:0] cell_q;

	// =================================================================
	// Helpers
	// A select past the last row line gives no edge rather than an unknown.
	function automatic logic row_edge(input logic [RL-1:0] now, input logic [RL-1:0] was,
			input logic [2:0] sel, input logic fall);
		row_edge = 1'b0;
		if (sel < 3'(RL)) begin
			row_edge = (now[sel] ^ was[sel]) & (now[sel] ^ fall);
		end
	endfunction

	function automatic logic [31:0] reg_read(input lcc_cluster_s s, input logic [7:0] a);
		logic [3:0] idx;
		idx = a[`LCC_IDX_HI:`LCC_IDX_LO];
		reg_read = '0;
		if ((a & `LCC_BLOCK_MASK) == `LCC_OFF_CFG) begin
			reg_read = s.cfg[idx];
		end else if ((a & `LCC_BLOCK_MASK) == `LCC_OFF_ROUTE) begin
			reg_read = {8'h00, s.route[idx]};
		end else if (a == `LCC_OFF_CTRL) begin
			reg_read = s.ctrl;
		end else if (a == `LCC_OFF_STAT) begin
			reg_read = {16'h0000, s.q};
		end else if (a == `LCC_OFF_COMB) begin
			reg_read = {16'h0000, s.comb};
		end
	endfunction

	// =================================================================
	// Cluster control generation
	// RULE_10: two clock ticks, two enables, two clears, sclr and sload.
	always_comb begin
		edge_one = row_edge(i_row_clock, st_r.row_prev,
			st_r.ctrl.clk1_sel, st_r.ctrl.clk1_fall); // RULE_17
		edge_two = row_edge(i_row_clock, st_r.row_prev,
			st_r.ctrl.clk2_sel, st_r.ctrl.clk2_fall); // RULE_15 RULE_17
		tick_one = edge_one & i_cluster_clock_enable_one; // RULE_14 RULE_16
		tick_two = edge_two & i_cluster_clock_enable_two; // RULE_14 RULE_16
		dev_clr = st_r.ctrl.dev_rst_en & ~st_r.rst_sync[1]; // RULE_20 RULE_23
		pool = {st_r.local_out, i_right_link, i_left_link, i_interconnect}; // RULE_09
		take = i_hsel & i_hready & i_htrans[`LCC_HTRANS_BIT];
		wr = st_r.ph_valid & st_r.ph_write;
		for (int i = 0; i < N; i++) begin
			pmask[i] = st_r.cfg[i].preset;
		end
	end

	// The first cluster of a column switches its carry input off.
	assign carry[0] = st_r.ctrl.carry_en & i_carry_in; // RULE_06
	assign chain[0] = i_reg_chain_in;

	// =================================================================
	// Cells
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_cell // RULE_07
			logic [3:0] din;
			always_comb begin
				for (int k = 0; k < 4; k++) begin
					din[k] = pool[st_r.route[gi][k]];
				end
			end
			assign chain[gi+1] = cell_q[gi]; // RULE_08
			lcc_cell u_cell (
				.i_clock(i_clock),
				.i_srst(i_srst),
				.i_cfg(st_r.cfg[gi]),
				.i_data(din),
				.i_carry_in(carry[gi]),
				.i_chain_in(chain[gi]),
				.i_tick_one(tick_one),
				.i_tick_two(tick_two),
				.i_clear_one(i_cluster_async_clear_one),
				.i_clear_two(i_cluster_async_clear_two),
				.i_sync_clear(i_sync_clear),
				.i_sync_load(i_sync_load),
				.i_dev_clr(dev_clr),
				.o_lut(cell_lut[gi]),
				.o_q(cell_q[gi]),
				.o_carry_out(carry[gi+1]) // RULE_06
			);
		end
	endgenerate

	// =================================================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.row_prev = i_row_clock;
		st_nxt.rst_sync = {st_r.rst_sync[0], i_device_wide_reset_n};
		st_nxt.hreadyout = 1'b1;
		st_nxt.hresp = `LCC_RESP_OKAY;
		if (wr) begin
			if ((st_r.ph_addr & `LCC_BLOCK_MASK) == `LCC_OFF_CFG) begin
				st_nxt.cfg[st_r.ph_addr[`LCC_IDX_HI:`LCC_IDX_LO]] = i_hwdata;
			end else if ((st_r.ph_addr & `LCC_BLOCK_MASK) == `LCC_OFF_ROUTE) begin
				st_nxt.route[st_r.ph_addr[`LCC_IDX_HI:`LCC_IDX_LO]] = i_hwdata[23:0];
			end else if (st_r.ph_addr == `LCC_OFF_CTRL) begin
				st_nxt.ctrl = i_hwdata;
			end
		end
		st_nxt.ph_valid = take;
		st_nxt.ph_write = i_hwrite;
		st_nxt.ph_addr = i_haddr[7:0];
		st_nxt.comb = cell_lut; // RULE_22
		st_nxt.q = cell_q; // RULE_05
		for (int i = 0; i < N; i++) begin
			// Packing: the table drives one path, the register the other.
			st_nxt.direct[i] = st_r.cfg[i].out_reg ? cell_q[i] : cell_lut[i]; // RULE_03
			st_nxt.local_out[i] = st_r.cfg[i].out_reg ? cell_lut[i] : cell_q[i];
		end
		st_nxt.carry_out = carry[N]; // RULE_06
		st_nxt.chain_out = chain[N];
		// Reading the next state makes a read right after a write see it.
		if (take && !i_hwrite) begin
			st_nxt.hrdata = reg_read(st_nxt, i_haddr[7:0]);
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			st_r <= '0;
			st_r.rst_sync <= `LCC_RST_SYNC;
			st_r.hreadyout <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// =================================================================
	// Outputs
	assign o_hreadyout = st_r.hreadyout;
	assign o_hrdata = st_r.hrdata;
	assign o_hresp = st_r.hresp;
	assign o_cell_comb = st_r.comb;
	assign o_cell_reg = st_r.q;
	assign o_direct_link = st_r.direct;
	assign o_carry_out = st_r.carry_out;
	assign o_reg_chain_out = st_r.chain_out;

	// =================================================================
	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);

	logic quiet;
	logic chain_case;
	assign quiet = !tick_one && !tick_two && !dev_clr && !wr &&
		!i_cluster_async_clear_one && !i_cluster_async_clear_two;
	assign chain_case = st_r.cfg[1].chain && !st_r.cfg[1].clk_sel &&
		!st_r.cfg[1].preset && st_r.cfg[1].ff == lcc_pkg::LCC_FF_D &&
		tick_one && !i_sync_clear && !i_sync_load && !dev_clr && !wr &&
		!i_cluster_async_clear_one && !i_cluster_async_clear_two;

	chk_stat_read: assert property (
		take && !i_hwrite && i_haddr[7:0] == `LCC_OFF_STAT |=> o_hrdata[15:0] == st_r.q
	) else $error("Status read returned stale cell values.");
	chk_ctrl_write: assert property (
		take && i_hwrite && i_haddr[7:0] == `LCC_OFF_CTRL ##1 1 |=> st_r.ctrl == $past(i_hwdata)
	) else $error("Control write was not stored.");
	chk_gate_stops: assert property ( // RULE_16
		quiet |=> ##1 st_r.q == $past(st_r.q)
	) else $error("Cells moved while both cluster clocks were stopped.");
	chk_sync_clear_all: assert property ( // RULE_13
		tick_one && tick_two && i_sync_clear && pmask == '0 && !dev_clr && !wr &&
		!i_cluster_async_clear_one && !i_cluster_async_clear_two |=> ##1 st_r.q == '0
	) else $error("Synchronous clear missed a register.");
	chk_dev_reset: assert property ( // RULE_20
		dev_clr && !wr |=> ##1 st_r.q == $past(pmask)
	) else $error("Device reset did not clear every register.");
	chk_reset_sync: assert property ( // RULE_23
		(!i_device_wide_reset_n && st_r.ctrl.dev_rst_en && !wr) ##1 !wr |-> ##1 dev_clr
	) else $error("Low device reset did not reach the cells in two cycles.");
	chk_chain_shift: assert property ( // RULE_08
		chain_case |=> ##1 st_r.q[1] == $past(st_r.q[0])
	) else $error("Register chain did not shift.");
	chk_edges_apart: assert property ( // RULE_15
		st_r.ctrl.clk1_sel == st_r.ctrl.clk2_sel &&
		st_r.ctrl.clk1_fall != st_r.ctrl.clk2_fall |-> !(edge_one && edge_two)
	) else $error("Rising and falling ticks of one line coincided.");

	cov_carry_out: cover property (st_r.ctrl.carry_en && st_r.carry_out);
	cov_chain: cover property (chain_case ##2 st_r.q[1]);
	cov_dev_reset: cover property (dev_clr ##2 st_r.q == pmask);
endmodule // lcc_cluster

// [test/lcc_partner.sv]
// Purpose: neighbouring cluster that drives the direct links, carry and chain.
// Assumes: one clock; new values are loaded on a one-cycle strobe.
// Notes: outputs are registered, as a real neighbour's would be.
module lcc_partner (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_srst,
	// Values to present
	input wire logic i_load,
	input wire logic [33:0] i_value,
	// Towards the cluster
	output logic [15:0] o_left_link,
	output logic [15:0] o_right_link,
	output logic o_carry,
	output logic o_chain
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [15:0] left;
		logic [15:0] right;
		logic carry;
		logic chain;
	} lcc_nb_s;
	lcc_nb_s st_r;
	lcc_nb_s st_nxt;
	always_comb begin
		st_nxt = st_r;
		if (i_load) begin
			st_nxt = i_value;
		end
	end
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign o_left_link = st_r.left;
	assign o_right_link = st_r.right;
	assign o_carry = st_r.carry;
	assign o_chain = st_r.chain;
endmodule // lcc_partner

// [test/tb_lcc_cluster.sv]
// Purpose: self-checking bench of one logic cluster.
// Assumes: zero-wait AHB-Lite slave; registered cluster outputs.
// Notes: waits of three cycles cover the one-cycle output lags.
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_lcc_cluster;
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================================
	// Signals
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [5:0] row = 6'h0;
	logic en1 = 1'b0;
	logic clr1 = 1'b0;
	logic sclr = 1'b0;
	logic sload = 1'b0;
	logic [15:0] dlink;
	logic devn = 1'b1;
	logic [15:0] ic = 16'h0;
	logic pload = 1'b0;
	logic [33:0] pval = 34'h0;
	logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic [15:0] comb;
	logic [15:0] q;
	logic cout;
	logic chout;
	logic [15:0] left;
	logic [15:0] right;
	logic pcarry;
	logic pchain;
	int fail_count = 0;
	int num_checks = 0;
	always #5 clk = ~clk;
	// =========================================================
	// Instances
	lcc_partner i_lcc_partner (.i_clock(clk), .i_srst(srst), .i_load(pload),
		.i_value(pval), .o_left_link(left), .o_right_link(right), .o_carry(pcarry),
		.o_chain(pchain));
	lcc_cluster i_lcc_cluster (.i_clock(clk), .i_srst(srst), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata),
		.o_hresp(hresp), .i_row_clock(row), .i_cluster_clock_enable_one(en1),
		.i_cluster_clock_enable_two(1'b0), .i_cluster_async_clear_one(clr1),
		.i_cluster_async_clear_two(1'b0), .i_sync_clear(sclr),
		.i_sync_load(sload),
		.i_device_wide_reset_n(devn), .i_interconnect(ic), .i_left_link(left),
		.i_right_link(right), .i_carry_in(pcarry), .i_reg_chain_in(pchain),
		.o_cell_comb(comb), .o_cell_reg(q), .o_direct_link(dlink), .o_carry_out(cout),
		.o_reg_chain_out(chout));
	// =========================================================
	// Tasks and functions
	task automatic test_done();
		$display("Checks: %0d, mismatches: %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 100);
		if (n >= 100) begin
			fail_count++;
			test_done();
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] rd;
		bus(1'b1, a, d, rd);
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] rd;
		bus(1'b0, a, 32'h0, rd);
		`CHK(rd, e)
	endtask
	task automatic neighbour(input logic [33:0] v);
		pval <= v;
		pload <= 1'b1;
		@(posedge clk);
		pload <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// A tick needs a rising edge on the selected row line, so lower it first.
	task automatic tick(input int ln, input logic en);
		en1 <= en;
		row <= 6'h0;
		repeat (2) @(posedge clk);
		row[ln] <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	function automatic logic [3:0] tab_idx(input logic cin);
		return {cin ? pcarry : ic[3], right[2], left[1], ic[0]};
	endfunction
	// =========================================================
	// Main sequence
	initial begin
		lcc_pkg::lcc_cfg_s c;
		lcc_pkg::lcc_ctrl_s k;
		logic [15:0] sh;
		logic e;
		logic x;
		int ln;
		void'($urandom(32'h25a2f375));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rdchk(32'h80, 32'h0);
		rdchk(32'h8c, 32'h0);
		k = '0;
		k.carry_en = 1'b1;
		wr(32'h80, k);
		wr(32'h40, {8'h0, 6'd3, 6'd34, 6'd17, 6'd0});
		for (int i = 0; i < 24; i++) begin
			c = '0;
			c.mask = 16'($urandom());
			c.cin_sel = i[0];
			wr(32'h0, c);
			ic <= 16'($urandom());
			neighbour(34'({$urandom(), $urandom()}));
			`CHK(comb[0], c.mask[tab_idx(c.cin_sel)])
		end
		x = 1'b0;
		// The register drives the direct link, the table the local path.
		c.out_reg = 1'b1;
		wr(32'h0, c);
		for (int i = 0; i < 12; i++) begin
			ln = $urandom_range(5);
			k.clk1_sel = 3'(ln);
			wr(32'h80, k);
			e = (i < 2) | 1'($urandom());
			tick(ln, e);
			x = e ? c.mask[tab_idx(c.cin_sel)] : x;
			`CHK(q[0], x)
			`CHK(dlink[0], x)
		end
		c = '0;
		c.mask = 16'hffff;
		wr(32'h0, c);
		c.mask = 16'h0;
		c.preset = 1'b1;
		wr(32'h4, c);
		k.dev_rst_en = 1'b1;
		wr(32'h80, k);
		for (int kind = 0; kind < 3; kind++) begin
			tick(ln, 1'b1);
			`CHK(q[1:0], 2'b01)
			clr1 <= (kind == 0);
			devn <= (kind != 2);
			if (kind == 1) begin
				sclr <= 1'b1;
				tick(ln, 1'b1);
			end
			repeat (3) @(posedge clk);
			clr1 <= 1'b0;
			sclr <= 1'b0;
			devn <= 1'b1;
			repeat (3) @(posedge clk);
			`CHK(q[1:0], 2'b10)
		end
		// Load takes data input 2; cell 1 routes every input to pool bit 0.
		sload <= 1'b1;
		tick(ln, 1'b1);
		sload <= 1'b0;
		@(posedge clk);
		`CHK(q[1:0], {ic[0], right[2]})
		// Every cell adds and shifts, so one setup serves both chains.
		c = '0;
		c.arith = 1'b1;
		c.chain = 1'b1;
		for (int i = 0; i < 16; i++) begin
			wr(32'(4 * i), c);
			wr(32'(32'h40 + 4 * i), {20'h0, 6'd1, 6'd0});
		end
		for (int i = 0; i < 10; i++) begin
			ic <= 16'($urandom());
			neighbour(34'({$urandom(), $urandom()}));
			x = (ic[0] & ic[1]) | ((ic[0] ^ ic[1]) & pcarry);
			`CHK(cout, x)
		end
		sh = 16'($urandom());
		for (int i = 15; i >= 0; i--) begin
			neighbour({33'h0, sh[i]});
			tick(ln, 1'b1);
		end
		`CHK(q, sh)
		`CHK(chout, sh[15])
		rdchk(32'h84, {16'h0, sh});
		test_done();
	end
	initial begin
		#1000000;
		fail_count++;
		test_done();
	end
endmodule // tb_lcc_cluster
